/* fps_host.v */
// Host-side controller that drives a parallel flash through its command sequences.
`timescale 1ns/1ps
`include "fps_defs.vh"

module fps_host
(
	// Clock, reset and clock enable.
	input wire mclk_i,
	input wire nrst_i,
	input wire ce_i,
	// User command port.
	input wire cmd_valid_i,
	input wire [3:0] cmd_op_i,
	input wire [`FPS_AW-1:0] cmd_addr_i,
	input wire [`FPS_DW-1:0] cmd_data_i,
	output wire cmd_ready_o,
	output reg done_o,
	output reg err_o,
	output reg [`FPS_DW-1:0] rdata_o,
	output reg window_open_o,
	// Flash pins.
	output reg [`FPS_AW-1:0] fl_addr_o,
	input wire [`FPS_DW-1:0] fl_dq_i,
	output reg [`FPS_DW-1:0] fl_dq_o,
	output reg fl_dq_oe_o,
	output reg fl_ce_n_o,
	output reg fl_we_n_o,
	output reg fl_oe_n_o
);

	////////////////////////////////////////////////////////////////////////
	// States and read kinds.
	localparam S_IDLE = 3'd0;
	localparam S_WA = 3'd1;
	localparam S_WB = 3'd2;
	localparam S_WC = 3'd3;
	localparam S_RA = 3'd4;
	localparam S_RB = 3'd5;
	localparam S_RC = 3'd6;
	localparam K_USER = 2'd0;
	localparam K_POLL1 = 2'd1;
	localparam K_POLL2 = 2'd2;
	localparam [`FPS_WIN_CW-1:0] GAP_CYC = `FPS_GAP_CYC;

	reg [2:0] state;
	reg [3:0] op;
	reg [`FPS_AW-1:0] addr;
	reg [`FPS_DW-1:0] data;
	reg [2:0] idx;
	reg [2:0] len;
	reg [1:0] kind;
	reg [`FPS_DW-1:0] prev;
	reg abort;
	reg [`FPS_WIN_CW-1:0] win_cnt;

	////////////////////////////////////////////////////////////////////////
	// Sequence tables.

	// Address of write number i of the sequence for command c.
	function [`FPS_AW-1:0] seq_addr;
		input [3:0] c;
		input [2:0] i;
		input [`FPS_AW-1:0] a;
		begin
			case (i)
				3'd0: seq_addr = (c == `FPS_OP_PROG || c == `FPS_OP_CHIP || c == `FPS_OP_SECT)
					? `FPS_ADR_UNL1 : a;
				3'd1: seq_addr = `FPS_ADR_UNL2;
				3'd2: seq_addr = `FPS_ADR_UNL1;
				3'd3: seq_addr = (c == `FPS_OP_PROG) ? a : `FPS_ADR_UNL1;
				3'd4: seq_addr = `FPS_ADR_UNL2;
				default: seq_addr = (c == `FPS_OP_SECT) ? a : `FPS_ADR_UNL1;
			endcase
		end
	endfunction

	// Data of write number i of the sequence for command c.
	function [`FPS_DW-1:0] seq_data;
		input [3:0] c;
		input [2:0] i;
		input [`FPS_DW-1:0] d;
		begin
			case (i)
				3'd0:
				begin
					case (c)
						`FPS_OP_ADDS: seq_data = `FPS_D_SECT;
						`FPS_OP_SUSP: seq_data = `FPS_D_SUSP;
						`FPS_OP_RESM: seq_data = `FPS_D_RESM;
						`FPS_OP_RST: seq_data = `FPS_D_RST;
						default: seq_data = `FPS_D_UNL1;
					endcase
				end
				3'd1: seq_data = `FPS_D_UNL2;
				3'd2: seq_data = (c == `FPS_OP_PROG) ? `FPS_D_PSET : `FPS_D_ESET;
				3'd3: seq_data = (c == `FPS_OP_PROG) ? d : `FPS_D_UNL1;
				3'd4: seq_data = `FPS_D_UNL2;
				default: seq_data = (c == `FPS_OP_CHIP) ? `FPS_D_CHIP : `FPS_D_SECT;
			endcase
		end
	endfunction

	// Number of write cycles for a command.
	function [2:0] seq_len;
		input [3:0] c;
		begin
			case (c)
				`FPS_OP_PROG: seq_len = `FPS_LEN_PROG;
				`FPS_OP_CHIP: seq_len = `FPS_LEN_ERASE;
				`FPS_OP_SECT: seq_len = `FPS_LEN_ERASE;
				default: seq_len = `FPS_LEN_ONE;
			endcase
		end
	endfunction

	// Commands whose last write is followed by polling until the device settles.
	function needs_poll;
		input [3:0] c;
		begin
			needs_poll = (c == `FPS_OP_PROG) || (c == `FPS_OP_CHIP) ||
				(c == `FPS_OP_SUSP) || (c == `FPS_OP_WAIT);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Handshake: a command is taken only when idle and the clock is enabled.
	assign cmd_ready_o = (state == S_IDLE) && ce_i;

	////////////////////////////////////////////////////////////////////////
	// Window timer, restarted one cycle after the rising strobe of the last write of each sector erase or sector add, on the edge where chip select rises.
	// Adding a sector is refused once the margin below the window has passed.
	always @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			win_cnt <= {`FPS_WIN_CW{1'b0}};
			window_open_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (state == S_WC && idx == len - 3'd1 &&
				(op == `FPS_OP_SECT || op == `FPS_OP_ADDS))
			begin
				win_cnt <= {`FPS_WIN_CW{1'b0}};
				window_open_o <= 1'b1;
			end
			else if (state == S_WC && op != `FPS_OP_SECT && op != `FPS_OP_ADDS)
				window_open_o <= 1'b0;
			else if (window_open_o)
			begin
				if (win_cnt >= GAP_CYC - 1'b1)
					window_open_o <= 1'b0;
				win_cnt <= win_cnt + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequencer: write cycles, read cycles and toggle polling.
	always @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state <= S_IDLE;
			op <= 4'h0;
			addr <= {`FPS_AW{1'b0}};
			data <= {`FPS_DW{1'b0}};
			idx <= 3'd0;
			len <= 3'd0;
			kind <= K_USER;
			prev <= {`FPS_DW{1'b0}};
			abort <= 1'b0;
			done_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= {`FPS_DW{1'b0}};
			fl_addr_o <= {`FPS_AW{1'b0}};
			fl_dq_o <= {`FPS_DW{1'b0}};
			fl_dq_oe_o <= 1'b0;
			fl_ce_n_o <= 1'b1;
			fl_we_n_o <= 1'b1;
			fl_oe_n_o <= 1'b1;
		end
		else if (ce_i)
		begin
			done_o <= 1'b0;
			case (state)
				S_IDLE:
				begin
					if (cmd_valid_i)
					begin
						op <= cmd_op_i;
						addr <= cmd_addr_i;
						data <= cmd_data_i;
						idx <= 3'd0;
						len <= seq_len(cmd_op_i);
						abort <= 1'b0;
						err_o <= 1'b0;
						fl_addr_o <= cmd_addr_i;
						if (cmd_op_i == `FPS_OP_ADDS && !window_open_o)
						begin
							err_o <= 1'b1;
							done_o <= 1'b1;
						end
						else if (cmd_op_i == `FPS_OP_READ)
						begin
							kind <= K_USER;
							state <= S_RA;
						end
						else if (cmd_op_i == `FPS_OP_WAIT)
						begin
							kind <= K_POLL1;
							state <= S_RA;
						end
						else
							state <= S_WA;
					end
				end
				S_WA:
				begin
					// Address and data are driven on the same edge on which both strobes fall.
					fl_addr_o <= seq_addr(op, idx, addr);
					fl_dq_o <= seq_data(op, idx, data);
					fl_dq_oe_o <= 1'b1;
					fl_ce_n_o <= 1'b0;
					fl_we_n_o <= 1'b0;
					state <= S_WB;
				end
				S_WB:
				begin
					// Write strobe rises here; the device latches the data.
					fl_we_n_o <= 1'b1;
					state <= S_WC;
				end
				S_WC:
				begin
					fl_ce_n_o <= 1'b1;
					fl_dq_oe_o <= 1'b0;
					if (idx != len - 3'd1)
					begin
						idx <= idx + 3'd1;
						state <= S_WA;
					end
					else if (needs_poll(op) && !abort)
					begin
						kind <= K_POLL1;
						state <= S_RA;
					end
					else
					begin
						// A failed algorithm reports its error together with done.
						if (abort)
							err_o <= 1'b1;
						done_o <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_RA:
				begin
					fl_ce_n_o <= 1'b0;
					fl_oe_n_o <= 1'b0;
					state <= S_RB;
				end
				S_RB:
				begin
					state <= S_RC;
				end
				S_RC:
				begin
					fl_ce_n_o <= 1'b1;
					fl_oe_n_o <= 1'b1;
					rdata_o <= fl_dq_i;
					case (kind)
						K_POLL1:
						begin
							prev <= fl_dq_i;
							kind <= K_POLL2;
							state <= S_RA;
						end
						K_POLL2:
						begin
							if (prev[`FPS_BIT_TOGGLE] == fl_dq_i[`FPS_BIT_TOGGLE])
							begin
								done_o <= 1'b1;
								state <= S_IDLE;
							end
							else if (fl_dq_i[`FPS_BIT_LIMIT])
							begin
								// Still toggling with the limit flag up: failed, send reset.
								abort <= 1'b1;
								op <= `FPS_OP_RST;
								idx <= 3'd0;
								len <= `FPS_LEN_ONE;
								state <= S_WA;
							end
							else
							begin
								kind <= K_POLL1;
								state <= S_RA;
							end
						end
						default:
						begin
							done_o <= 1'b1;
							state <= S_IDLE;
						end
					endcase
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

endmodule // fps_host

/* fps_defs.vh */
// Constants for the flash program and erase host sequencer.
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH

// Bus widths.
`define FPS_AW 19
`define FPS_DW 8

// User command codes.
`define FPS_OP_READ 4'h0
`define FPS_OP_PROG 4'h1
`define FPS_OP_CHIP 4'h2
`define FPS_OP_SECT 4'h3
`define FPS_OP_ADDS 4'h4
`define FPS_OP_SUSP 4'h5
`define FPS_OP_RESM 4'h6
`define FPS_OP_RST 4'h7
`define FPS_OP_WAIT 4'h8

// Unlock and command addresses.
`define FPS_ADR_UNL1 19'h0_0555
`define FPS_ADR_UNL2 19'h0_02AA

// Command data values.
`define FPS_D_UNL1 8'hAA
`define FPS_D_UNL2 8'h55
`define FPS_D_PSET 8'hA0
`define FPS_D_ESET 8'h80
`define FPS_D_CHIP 8'h10
`define FPS_D_SECT 8'h30
`define FPS_D_SUSP 8'hB0
`define FPS_D_RESM 8'h30
`define FPS_D_RST 8'hF0

// Sequence lengths in write cycles.
`define FPS_LEN_PROG 3'h4
`define FPS_LEN_ERASE 3'h6
`define FPS_LEN_ONE 3'h1

// Status bit positions.
`define FPS_BIT_TOGGLE 6
`define FPS_BIT_LIMIT 5
`define FPS_BIT_WINDOW 3

// Timing: clock rate, sector erase window and the host's safety margin.
`define FPS_CLK_MHZ 10
`define FPS_WINDOW_US 50
`define FPS_GAP_US 45
`define FPS_GAP_CYC (`FPS_GAP_US * `FPS_CLK_MHZ)
`define FPS_WIN_CW 10

`endif

/* fps_host_assertions.sv */
// Port assertions for the flash host sequencer.
`timescale 1ns/1ps
////////////////////////////////////////
module fps_host_chk
(
	// Clock and reset.
	input mclk_i,
	input nrst_i,
	// Command port.
	input cmd_valid_i,
	input [3:0] cmd_op_i,
	input cmd_ready_o,
	input done_o,
	input err_o,
	input window_open_o,
	// Flash pins.
	input [18:0] fl_addr_o,
	input [7:0] fl_dq_o,
	input fl_dq_oe_o,
	input fl_ce_n_o,
	input fl_we_n_o,
	input fl_oe_n_o
);
	// All checks sample on the clock and rest in reset.
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	wire tk = cmd_valid_i && cmd_ready_o;
	a_write_strobes: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
		else $error("write strobe outside a select");
	a_pulse_shape: assert property ($fell(fl_we_n_o) |=> $rose(fl_we_n_o) ##1 fl_ce_n_o)
		else $error("bad write pulse shape");
	a_data_held: assert property (!fl_we_n_o |=> $stable(fl_dq_o) && fl_dq_oe_o)
		else $error("data moved under the strobe");
	a_bus_free: assert property (!fl_oe_n_o |-> !fl_dq_oe_o)
		else $error("bus driven during a read");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done longer than a cycle");
	a_err_done: assert property ($rose(err_o) |-> done_o)
		else $error("error without done");
	a_add_late: assert property (tk && cmd_op_i == 4'h4 && !window_open_o
		|-> ##[1:2] done_o && err_o && fl_ce_n_o) else $error("late add not refused");
	a_unlock_first: assert property (tk && cmd_op_i == 4'h1
		|-> ##2 fl_dq_o == 8'hAA && fl_addr_o[10:0] == 11'h555) else $error("bad unlock");
	a_suspend_code: assert property (tk && cmd_op_i == 4'h5 |-> ##2 fl_dq_o == 8'hB0)
		else $error("bad suspend code");
	a_resume_done: assert property (tk && cmd_op_i == 4'h6
		|-> ##2 fl_dq_o == 8'h30 ##2 done_o) else $error("bad resume write");
endmodule // fps_host_chk

bind fps_host fps_host_chk u_chk (.*);

/* fps_flash.sv */
// Behavioural flash device on the host's bus pins.
`timescale 1ns/1ps
////////////////////////////////////////
module fps_flash #(parameter int WIN = 500, ERS = 300, PRG = 30)
(
	// Model clock.
	input wire clk_i,
	// Bus pins.
	input wire [18:0] a_i,
	input wire [7:0] d_i,
	input wire ce_n_i,
	input wire we_n_i,
	input wire oe_n_i,
	output wire [7:0] q_o
);
	logic [7:0] mem [8][16];
	logic [7:0] sm = 0;
	logic [7:0] last = 0;
	logic tog = 0, bad = 0, sus = 0, chip = 0;
	int n = 0, pb = 0, eb = 0, win = 0;
	wire st;
	initial foreach (mem[i, j]) mem[i][j] = 8'hFF;
	// Status shows while an algorithm runs or a suspended sector is read.
	assign st = pb > 0 || eb > 0 && !sus || win > 0 || bad || sus && sm[a_i[18:16]];
	// Commands are taken on the rising write strobe.
	always @(posedge we_n_i)
		if (!ce_n_i)
		begin
			if (pb > 0 || eb > 0 && !sus)
			begin
				if (d_i == 8'hB0 && eb > 0 && !chip)
					sus = 1;
			end
			else if (win > 0)
			begin
				win = d_i == 8'h30 ? WIN : 0;
				if (d_i == 8'h30)
					sm[a_i[18:16]] = 1;
				else if (d_i == 8'hB0)
				begin
					sus = 1;
					eb = ERS;
				end
				else
					sm = 0;
			end
			else if (d_i == 8'hF0)
			begin
				n = 0;
				bad = 0;
			end
			else if (sus && n == 0 && d_i == 8'h30)
				sus = 0;
			else
				case (n)
					0: n = d_i == 8'hAA && a_i[10:0] == 11'h555;
					1: n = d_i == 8'h55 && a_i[10:0] == 11'h2AA ? 2 : 0;
					2: n = d_i == 8'hA0 ? 3 : d_i == 8'h80 && !sus ? 4 : 0;
					3:
					begin
						// Writing a one over a zero hangs with the limit flag.
						bad = |(d_i & ~mem[a_i[18:16]][a_i[3:0]]);
						mem[a_i[18:16]][a_i[3:0]] &= d_i;
						pb = bad ? 0 : PRG;
						n = 0;
					end
					4: n = d_i == 8'hAA ? 5 : 0;
					5: n = d_i == 8'h55 ? 6 : 0;
					default:
					begin
						n = 0;
						chip = d_i == 8'h10;
						eb = chip ? ERS : 0;
						win = d_i == 8'h30 ? WIN : 0;
						sm = 8'h1 << a_i[18:16];
					end
				endcase
		end
	// Timers count in model clock cycles.
	always @(posedge clk_i)
	begin
		if (win == 1) eb = ERS;
		if (win > 0) win--;
		if (pb > 0) pb--;
		if (eb == 1 && !sus)
			for (int s = 0; s < 8; s++)
				if (chip || sm[s])
					foreach (mem[s][j]) mem[s][j] = 8'hFF;
		if (eb > 0 && !sus) eb--;
		if (!ce_n_i && !oe_n_i) last = q_o;
	end
	// Each status read toggles bit six.
	always @(negedge oe_n_i)
		if (!ce_n_i && st) tog = ~tog;
	// A released bus shows the inverse of its last value.
	assign q_o = ce_n_i || oe_n_i ? ~last : st ? {sus, tog, bad, 1'b0, win == 0, 3'h0}
		: mem[a_i[18:16]][a_i[3:0]];
endmodule // fps_flash

/* fps_host_tb.sv */
// Self-checking bench for the flash host sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
////////////////////////////////////////
module fps_host_tb;
	reg mclk_i = 0;
	reg nrst_i = 0;
	reg ce_i = 1;
	reg cmd_valid_i = 0;
	reg [3:0] cmd_op_i = 0;
	reg [18:0] cmd_addr_i = 0;
	reg [7:0] cmd_data_i = 0;
	wire cmd_ready_o, done_o, err_o, window_open_o, fl_dq_oe_o, fl_ce_n_o, fl_we_n_o, fl_oe_n_o;
	wire [7:0] rdata_o, fl_dq_o, q, dq;
	wire [18:0] fl_addr_o;
	int mismatches = 0;
	int n_compared = 0;
	int t = 0;
	// Clock and the resolved data bus.
	always #50 mclk_i = ~mclk_i;
	assign dq = fl_dq_oe_o ? fl_dq_o : q;
	fps_host dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
		.cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
		.cmd_ready_o(cmd_ready_o), .done_o(done_o), .err_o(err_o), .rdata_o(rdata_o),
		.window_open_o(window_open_o), .fl_addr_o(fl_addr_o), .fl_dq_i(dq), .fl_dq_o(fl_dq_o),
		.fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));
	fps_flash u_fl (.clk_i(mclk_i), .a_i(fl_addr_o), .d_i(dq), .ce_n_i(fl_ce_n_o),
		.we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o), .q_o(q));
	// Issues one command and waits for its completion.
	task automatic run(input [3:0] op, input [18:0] a, input [7:0] d);
		int n;
		@(posedge mclk_i);
		cmd_valid_i <= 1;
		cmd_op_i <= op;
		cmd_addr_i <= a;
		cmd_data_i <= d;
		@(negedge mclk_i);
		while (cmd_ready_o !== 1'b1) @(negedge mclk_i);
		@(posedge mclk_i);
		cmd_valid_i <= 0;
		for (n = 0; n < 9000 && done_o !== 1'b1; n++) @(negedge mclk_i);
		if (n == 9000) mismatches++;
	endtask
	// Reads one byte and compares it.
	task automatic rd(input [18:0] a, input [7:0] e);
		run(0, a, 0);
		`CHK("rdata", e, rdata_o)
	endtask
	// Marks the end of one test.
	task automatic tend;
		t++;
		$display("test %0d end", t);
	endtask
	// Prints the verdict and ends the run.
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog.
	initial
	begin
		#6000000;
		mismatches++;
		conclude;
	end
	// Test sequence.
	initial
	begin
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1;
		run(1, 19'h1_2345, 8'h5A);
		`CHK("err", 1'b0, err_o)
		rd(19'h1_2345, 8'h5A);
		run(1, 19'h7_0001, 8'h0F);
		rd(19'h7_0001, 8'h0F);
		run(1, 19'h1_2345, 8'hA5);
		`CHK("err", 1'b1, err_o)
		rd(19'h1_2345, 8'h00);
		tend;
		run(2, 0, 0);
		`CHK("err", 1'b0, err_o)
		rd(19'h7_0001, 8'hFF);
		tend;
		run(1, 19'h2_0003, 8'h11);
		run(3, 19'h2_0000, 0);
		`CHK("win", 1'b1, window_open_o)
		run(4, 19'h5_0000, 0);
		`CHK("err", 1'b0, err_o)
		run(5, 0, 0);
		run(1, 19'h6_0003, 8'h22);
		rd(19'h6_0003, 8'h22);
		run(0, 19'h2_0003, 0);
		`CHK("stat", 1'b1, rdata_o[7])
		run(6, 0, 0);
		run(8, 19'h2_0000, 0);
		rd(19'h2_0003, 8'hFF);
		tend;
		run(3, 19'h3_0000, 0);
		repeat (470) @(negedge mclk_i);
		run(4, 19'h4_0000, 0);
		`CHK("err", 1'b1, err_o)
		`CHK("win", 1'b0, window_open_o)
		run(8, 19'h3_0000, 0);
		`CHK("err", 1'b0, err_o)
		tend;
		conclude;
	end
endmodule // fps_host_tb
